// ===== dv/host_cpu_model.sv
`timescale 1ns/10ps

// ************************************************************
// Host processor: toggles the kick line from its main loop
// ************************************************************
module host_cpu_model
(
  input  wire logic       clk,        // System clock
  input  wire logic       reset_n,    // Supervisor reset, low
  input  wire logic       kick_en,    // Main loop alive
  input  wire logic [7:0] period,     // Cycles between toggles
  input  wire logic       pulse_req,  // Each change flips the line once
  output logic            kick_out    // Kick line
);
  int   cnt        = 0;
  logic pulse_prev = 1'b0;
  logic kick_r     = 1'b0;  // Line starts low, as after a processor reset

  assign kick_out = kick_r;

  // Toggles while running; a stall simply leaves the line still.
  // A request held one cycle gives a pulse one clock wide, the
  // narrowest the device must catch; it takes priority over the loop
  always @(negedge clk)
  begin
    pulse_prev <= pulse_req;
    if (pulse_req != pulse_prev)
      kick_r <= ~kick_r;
    else if (!reset_n || !kick_en)
      cnt <= 0;
    else if (cnt >= int'(period) - 1)
    begin
      cnt    <= 0;
      kick_r <= ~kick_r;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// ===== dv/supervisor_reset_watchdog_tb.sv
`timescale 1ns/10ps

// ************************************************************
// Bench for the supervisor with short hold and timeout counts
// ************************************************************
module supervisor_reset_watchdog_tb;
  localparam int HOLD  = 20;  // Short hold keeps the run brief
  localparam int WDOG  = 40;  // Short watchdog timeout
  localparam int SLACK = 8;   // Sync and register latency allowance

  logic       clk;
  logic       rst;
  logic       supply_low;
  logic       pf_sense;
  logic       manual_n;
  logic       manual_drv;
  logic       kick_en;
  logic [7:0] kick_period;
  logic       pulse_req;
  logic       rst_hi;
  logic       rst_lo;
  logic       wdo_n;
  logic       pfo_n;
  wire        kick;
  tri1        manual_w;  // Pull-up, as the pin has when floating
  int         seed;
  int         fail_count;
  int         num_checks;
  int         cycles = 0;
  int         n;
  int         k;

  assign manual_w = manual_drv ? manual_n : 1'bz;

  supervisor_reset_watchdog
  #(
    .HOLD_CYCLES (HOLD),
    .WDOG_CYCLES (WDOG)
  )
  dut
  (
    .CLK                   (clk),
    .RST                   (rst),
    .SUPPLY_LOW_IN         (supply_low),
    .POWERFAIL_SENSE_IN    (pf_sense),
    .MANUAL_RESET_IN_N     (manual_w),
    .WATCHDOG_KICK_IN      (kick),
    .RESET_OUT             (rst_hi),
    .RESET_OUT_N           (rst_lo),
    .WATCHDOG_ALARM_OUT_N  (wdo_n),
    .POWERFAIL_ALARM_OUT_N (pfo_n)
  );

  host_cpu_model host
  (
    .clk       (clk),
    .reset_n   (rst_lo),
    .kick_en   (kick_en),
    .period    (kick_period),
    .pulse_req (pulse_req),
    .kick_out  (kick)
  );

  // ************************************************************
  // Clock, timeout and shared tasks
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole sequence needs well under the ceiling
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask

  // Expected levels of the complement reset and the power-fail alarm
  function automatic logic exp_rst_n(input logic active);
    return !active;
  endfunction

  function automatic logic exp_pfo(input logic sense);
    return sense;
  endfunction

  // One narrow kick: the model flips the line on each request change
  task automatic kick_pulse();
    pulse_req <= 1'b1;
    cyc(1);
    pulse_req <= 1'b0;
    cyc(1);
  endtask

  // Bounded wait for release; pre counts cycles already spent
  task automatic check_hold(input int pre);
    int len;
    n = 0;
    while (rst_hi !== 1'b0 && n < HOLD + 3 * SLACK)
    begin
      cyc(1);
      n++;
    end
    len = n + pre;
    check(len >= HOLD && len <= HOLD + SLACK, 1'b1, "hold length");
    check(rst_hi, 1'b0, "reset released");
    check(rst_lo, exp_rst_n(1'b0), "complement output");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    seed        = 47687;
    fail_count  = 0;
    num_checks  = 0;
    rst         = 1'b1;
    supply_low  = 1'b0;
    pf_sense    = 1'b1;
    manual_n    = 1'b1;
    manual_drv  = 1'b1;
    kick_en     = 1'b0;
    pulse_req   = 1'b0;
    kick_period = 8'h08;
    cyc(10);
    rst = 1'b0;
    check_hold(0);
    // Regular kicks at random periods, all inside the timeout
    kick_en <= 1'b1;
    repeat (6)
    begin
      k = $random(seed);
      kick_period <= {3'h0, k[4:0]} + 8'h02;
      repeat (30)
      begin
        cyc(1);
        check(wdo_n, 1'b1, "alarm while kicked");
      end
    end
    // Stall after one narrow kick, so the last edge is known
    kick_en <= 1'b0;
    kick_pulse();
    n = 0;
    while (wdo_n !== 1'b0 && n < WDOG + 2 * SLACK)
    begin
      cyc(1);
      n++;
    end
    check(n >= WDOG && wdo_n === 1'b0, 1'b1, "timeout length");
    check(rst_hi, 1'b0, "timeout left reset alone");
    repeat (30)
    begin
      cyc(1);
      check(wdo_n, 1'b0, "alarm held");
    end
    kick_pulse();
    cyc(SLACK);
    check(wdo_n, 1'b1, "narrow kick clears alarm");
    // Supply dip longer than the timeout, host still stalled
    supply_low = 1'b1;
    cyc(SLACK);
    k = $random(seed);
    repeat (WDOG + int'(k[5:0]))
    begin
      cyc(1);
      check(rst_hi, 1'b1, "reset while supply low");
      check(rst_lo, exp_rst_n(1'b1), "low reset while supply low");
      check(wdo_n, 1'b0, "alarm forced low");
      check(pfo_n, exp_pfo(pf_sense), "power-fail untouched");
    end
    supply_low = 1'b0;
    cyc(5);
    check(wdo_n, 1'b1, "alarm back at once");
    check_hold(5);
    cyc(WDOG - 4);
    check(wdo_n, 1'b1, "timer started at release");
    kick_period <= 8'h08;
    kick_en     <= 1'b1;
    // Second dip inside the hold restarts it in full
    supply_low = 1'b1;
    cyc(SLACK);
    supply_low = 1'b0;
    cyc(HOLD / 2);
    supply_low = 1'b1;
    cyc(4);
    supply_low = 1'b0;
    check_hold(0);
    // Manual reset of random width
    for (int i = 0; i < 3; i++)
    begin
      k = $random(seed);
      manual_n = 1'b0;
      cyc(SLACK + int'(k[2:0]));
      check(rst_hi, 1'b1, "manual reset taken");
      manual_n = 1'b1;
      check_hold(0);
    end
    // Floating manual input must stay inactive
    manual_drv = 1'b0;
    repeat (HOLD * 2)
    begin
      cyc(1);
      check(rst_hi, 1'b0, "floating manual input");
    end
    manual_drv = 1'b1;
    // Random sense levels; reset must not follow them
    repeat (24)
    begin
      k = $random(seed);
      pf_sense = k[0];
      cyc(4);
      check(pfo_n, exp_pfo(pf_sense), "alarm follows sense");
      check(rst_hi, 1'b0, "sense leaves reset");
    end
    // Second reset in mid-run: reset values, then a full hold again
    rst = 1'b1;
    cyc(3);
    check(rst_hi, 1'b1, "reset during RST");
    check(rst_lo, exp_rst_n(1'b1), "low reset during RST");
    check(wdo_n, 1'b1, "alarm idle during RST");
    rst = 1'b0;
    check_hold(0);
    test_done();
  end
endmodule

// ===== rtl/input_sync.sv
`timescale 1ns/10ps

// Two flop synchroniser for a group of level inputs
module input_sync
#(
  parameter int WIDTH = 3  // Number of levels
)
(
  input  wire logic             CLK,      // System clock
  input  wire logic             RST,      // Async reset, high
  input  wire logic [WIDTH-1:0] d_in,     // Asynchronous levels
  output logic      [WIDTH-1:0] q_out     // Synchronised levels
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  // ****************************************************************
  // Stage flops, one per bit
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // Reset to all ones: inputs idle as supply good, no alarms
      always_ff @(posedge CLK or posedge RST)
        if (RST)
        begin
          meta_r[i] <= 1'b1;
          hold_r[i] <= 1'b1;
        end
        else
        begin
          meta_r[i] <= d_in[i];
          hold_r[i] <= meta_r[i];
        end
    end
  endgenerate

  assign q_out = hold_r;

endmodule

// ===== rtl/kick_capture.sv
`timescale 1ns/10ps
`include "supervisor_map.svh"

// Asynchronous edge capture for the watchdog kick. Short pulses are
// held by toggle flops clocked on the pin itself, so a 50 ns pulse
// cannot slip between CLK edges; the toggles then cross two flops.
module kick_capture
(
  input  wire logic CLK,       // System clock
  input  wire logic RST,       // Async reset, high
  input  wire logic kick_pin,  // Raw kick input
  output logic      kick_edge  // One cycle per kick edge
);

  logic       tog_rise_r;
  logic       tog_fall_r;
  logic [1:0] sync_rise_r;
  logic [1:0] sync_fall_r;
  logic       seen_rise_r;
  logic       seen_fall_r;

  // ****************************************************************
  // Pulse stretchers on the pin edges
  // ****************************************************************
  // Rising edge toggle
  always_ff @(posedge kick_pin or posedge RST)
    if (RST)
      tog_rise_r <= 1'b0;
    else
      tog_rise_r <= ~tog_rise_r;

  // Falling edge toggle
  always_ff @(negedge kick_pin or posedge RST)
    if (RST)
      tog_fall_r <= 1'b0;
    else
      tog_fall_r <= ~tog_fall_r;

  // ****************************************************************
  // Crossing into CLK and edge report
  // ****************************************************************
  // Second stage alone feeds the compare
  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      sync_rise_r <= 2'h0;
      sync_fall_r <= 2'h0;
      seen_rise_r <= 1'b0;
      seen_fall_r <= 1'b0;
    end
    else
    begin
      sync_rise_r <= {sync_rise_r[0], tog_rise_r};
      sync_fall_r <= {sync_fall_r[0], tog_fall_r};
      seen_rise_r <= sync_rise_r[1];
      seen_fall_r <= sync_fall_r[1];
    end

  // Either direction clears the watchdog
  assign kick_edge = (sync_rise_r[1] ^ seen_rise_r)
                   | (sync_fall_r[1] ^ seen_fall_r);

endmodule

// ===== rtl/supervisor_map.svh
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

// ****************************************************************
// Timing figures as printed, and the clock they are counted against
// ****************************************************************
`define SUP_CLK_PERIOD_NS   50
`define SUP_HOLD_MS         200
`define SUP_WDOG_MS         1600
`define SUP_KICK_MIN_NS     50
// Cycles: least times round up, at least one cycle
`define SUP_HOLD_CYCLES  ((`SUP_HOLD_MS * 1000000 + `SUP_CLK_PERIOD_NS - 1) \
                          / `SUP_CLK_PERIOD_NS)
`define SUP_WDOG_CYCLES  ((`SUP_WDOG_MS * 1000000 + `SUP_CLK_PERIOD_NS - 1) \
                          / `SUP_CLK_PERIOD_NS)
`define SUP_SYNC_STAGES     2
`define SUP_POL_HIGH        2'h0
`define SUP_POL_LOW         2'h1
`define SUP_POL_BOTH        2'h2

`endif

// ===== rtl/supervisor_pkg.sv
package supervisor_pkg;

  // ****************************************************************
  // Types shared by the supervisor files
  // ****************************************************************
  typedef enum logic [1:0]
  {
    RST_HOLD_LOW = 2'h0,  // Supply low or manual reset held
    RST_TIMING   = 2'h1,  // Counting the hold period
    RST_RUN      = 2'h2   // Reset released
  } rst_state_t;

  // Synchronised inputs, travel together
  typedef struct packed
  {
    logic supply_low;
    logic pf_low;
    logic manual_n;
    logic kick_edge;
  } sync_in_t;

endpackage

// ===== rtl/supervisor_reset_watchdog.sv
// Summary of operation
// - Reset output stays active while supply is below threshold.
// - After supply recovers, reset holds a further 200 ms, then releases.
// - A new supply dip during the hold restarts the full 200 ms.
// - Output polarity is a build option: high, low, or both.
// - Manual reset low triggers reset; hold period debounces it.
// - Manual input tied high or floating never causes reset.
// - No kick edge for 1.6 s drives watchdog alarm low.
// - Every kick edge, rising or falling, clears the watchdog timer.
// - Kick pulses as short as 50 ns are caught and counted.
// - Watchdog timer held cleared while reset is active.
// - Supply low forces watchdog alarm low regardless of timer.
// - Power-fail alarm low when sense is below reference, else high.
// - Power-fail path is independent and never touches reset.
// - Timed-out alarm stays low until kick edge or reset clears it.
// - Alarm returns high at once when supply recovers.
// - Watchdog timeout alone never asserts reset.
`timescale 1ns/10ps
`include "supervisor_map.svh"

module supervisor_reset_watchdog
#(
  parameter logic [1:0] RESET_POLARITY = `SUP_POL_BOTH,  // Output style
  parameter int HOLD_CYCLES = `SUP_HOLD_CYCLES,  // 200 ms at CLK
  parameter int WDOG_CYCLES = `SUP_WDOG_CYCLES   // 1.6 s at CLK
)
(
  input  wire logic CLK,                    // 20 MHz clock
  input  wire logic RST,                    // Async reset, high
  input  wire logic SUPPLY_LOW_IN,          // Supply below threshold
  input  wire logic POWERFAIL_SENSE_IN,     // High: sense above ref
  input  wire logic MANUAL_RESET_IN_N,      // Manual reset, low
  input  wire logic WATCHDOG_KICK_IN,       // Kick from processor
  output logic      RESET_OUT,              // Reset, active high
  output logic      RESET_OUT_N,            // Reset, active low
  output logic      WATCHDOG_ALARM_OUT_N,   // Watchdog alarm, low
  output logic      POWERFAIL_ALARM_OUT_N   // Power-fail alarm, low
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int WW = $clog2(WDOG_CYCLES + 1);

  // Refused at elaboration, so a bad option never reaches silicon
  if (HOLD_CYCLES < 2 || WDOG_CYCLES < 2)
  begin : g_bad_count
    $error("Hold and watchdog counts must be at least two");
  end
  if (RESET_POLARITY > `SUP_POL_BOTH)
  begin : g_bad_pol
    $error("Unknown reset polarity option");
  end

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  supervisor_pkg::sync_in_t sin;
  logic [2:0]               lvl_q;
  logic                     kick_edge;

  // A floating manual pin is assumed pulled high at the pad,
  // so the logic only reacts to a real low level
  input_sync #(.WIDTH(3)) u_sync
  (
    .CLK     (CLK),
    .RST     (RST),
    .d_in    ({~SUPPLY_LOW_IN, POWERFAIL_SENSE_IN,
               MANUAL_RESET_IN_N}),
    .q_out   (lvl_q)
  );

  kick_capture u_kick
  (
    .CLK       (CLK),
    .RST       (RST),
    .kick_pin  (WATCHDOG_KICK_IN),
    .kick_edge (kick_edge)
  );

  // One driver for the whole carrier: supply, sense, manual, kick
  assign sin = {~lvl_q[2], ~lvl_q[1], lvl_q[0], kick_edge};

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  supervisor_pkg::rst_state_t st_r, st_nxt;
  logic [HW-1:0]              hold_cnt_r, hold_cnt_nxt;
  logic                       trig;

  // Supply low or manual low both restart the whole hold
  assign trig = sin.supply_low | ~sin.manual_n;

  // Next state; the watchdog never feeds this path
  always_comb
  begin
    st_nxt       = st_r;
    hold_cnt_nxt = hold_cnt_r;
    case (st_r)
      supervisor_pkg::RST_HOLD_LOW:
      begin
        hold_cnt_nxt = '0;
        if (!trig)
          st_nxt = supervisor_pkg::RST_TIMING;
      end
      supervisor_pkg::RST_TIMING:
      begin
        if (trig)
        begin
          st_nxt       = supervisor_pkg::RST_HOLD_LOW;
          hold_cnt_nxt = '0;
        end
        else if (hold_cnt_r == HW'(HOLD_CYCLES - 1))
          st_nxt = supervisor_pkg::RST_RUN;
        else
          hold_cnt_nxt = hold_cnt_r + HW'(1);
      end
      supervisor_pkg::RST_RUN:
        if (trig)
          st_nxt = supervisor_pkg::RST_HOLD_LOW;
      default:
        st_nxt = supervisor_pkg::RST_HOLD_LOW;
    endcase
  end

  // Power-on behaves like a supply recovery: full hold first
  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      st_r       <= supervisor_pkg::RST_HOLD_LOW;
      hold_cnt_r <= '0;
    end
    else
    begin
      st_r       <= st_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end

  logic rst_act_nxt;
  assign rst_act_nxt = (st_nxt != supervisor_pkg::RST_RUN);

  // ****************************************************************
  // Watchdog timer and alarm
  // ****************************************************************
  logic [WW-1:0] wd_cnt_r, wd_cnt_nxt;
  logic          wd_exp_r, wd_exp_nxt;

  // Reset and kick clear; expiry latches until one of them
  always_comb
  begin
    wd_cnt_nxt = wd_cnt_r;
    wd_exp_nxt = wd_exp_r;
    if (st_r != supervisor_pkg::RST_RUN || sin.kick_edge)
    begin
      wd_cnt_nxt = '0;
      wd_exp_nxt = 1'b0;
    end
    else if (wd_cnt_r == WW'(WDOG_CYCLES - 1))
      wd_exp_nxt = 1'b1;
    else
      wd_cnt_nxt = wd_cnt_r + WW'(1);
  end

  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      wd_cnt_r <= '0;
      wd_exp_r <= 1'b0;
    end
    else
    begin
      wd_cnt_r <= wd_cnt_nxt;
      wd_exp_r <= wd_exp_nxt;
    end

  // ****************************************************************
  // Output flops
  // ****************************************************************
  logic rst_hi_nxt, rst_lo_nxt, wdo_nxt, pfo_nxt;

  // Unused polarity of a single-ended option idles inactive
  always_comb
  begin
    rst_hi_nxt = 1'b0;
    rst_lo_nxt = 1'b1;
    if (RESET_POLARITY != `SUP_POL_LOW)
      rst_hi_nxt = rst_act_nxt;
    if (RESET_POLARITY != `SUP_POL_HIGH)
      rst_lo_nxt = ~rst_act_nxt;
    // Supply low forces the alarm; recovery lifts it at once
    wdo_nxt = ~(wd_exp_nxt | sin.supply_low);
    // Independent comparator path
    pfo_nxt = ~sin.pf_low;
  end

  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      RESET_OUT             <= (RESET_POLARITY != `SUP_POL_LOW);
      RESET_OUT_N           <= (RESET_POLARITY == `SUP_POL_HIGH);
      WATCHDOG_ALARM_OUT_N  <= 1'b1;
      POWERFAIL_ALARM_OUT_N <= 1'b1;
    end
    else
    begin
      RESET_OUT             <= rst_hi_nxt;
      RESET_OUT_N           <= rst_lo_nxt;
      WATCHDOG_ALARM_OUT_N  <= wdo_nxt;
      POWERFAIL_ALARM_OUT_N <= pfo_nxt;
    end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic rst_act;
  assign rst_act = (st_r != supervisor_pkg::RST_RUN);

  sequence s_recover;
    $fell(trig) ##1 (st_r == supervisor_pkg::RST_TIMING);
  endsequence

  a_reset_while_low: assert property (
    @(posedge CLK) disable iff (RST)
    sin.supply_low |=> rst_act)
    else $error("Reset released while supply low");

  a_hold_min: assert property (
    @(posedge CLK) disable iff (RST)
    s_recover |-> rst_act [*8])
    else $error("Reset released early after recovery");

  a_hold_restart: assert property (
    @(posedge CLK) disable iff (RST)
    (st_r == supervisor_pkg::RST_TIMING && trig)
      |=> (st_r == supervisor_pkg::RST_HOLD_LOW && hold_cnt_r == '0))
    else $error("Hold not restarted on new dip");

  a_manual_trig: assert property (
    @(posedge CLK) disable iff (RST)
    !sin.manual_n |=> ##1 (RESET_OUT_N == 1'b0
                           || RESET_POLARITY == `SUP_POL_HIGH))
    else $error("Manual reset did not assert output");

  a_wd_expire: assert property (
    @(posedge CLK) disable iff (RST)
    (wd_cnt_r == WW'(WDOG_CYCLES - 1) && !rst_act && !sin.kick_edge)
      |=> !WATCHDOG_ALARM_OUT_N)
    else $error("Watchdog alarm missing at timeout");

  a_kick_clears: assert property (
    @(posedge CLK) disable iff (RST)
    sin.kick_edge |=> (wd_cnt_r == '0 && !wd_exp_r))
    else $error("Kick did not clear watchdog");

  a_wd_held_rst: assert property (
    @(posedge CLK) disable iff (RST)
    rst_act |=> (wd_cnt_r == '0))
    else $error("Watchdog counted during reset");

  a_wdo_supply: assert property (
    @(posedge CLK) disable iff (RST)
    sin.supply_low |=> !WATCHDOG_ALARM_OUT_N)
    else $error("Alarm not forced by low supply");

  a_pfo_follow: assert property (
    @(posedge CLK) disable iff (RST)
    ##1 (POWERFAIL_ALARM_OUT_N == !$past(sin.pf_low)))
    else $error("Power-fail alarm mismatch");

  a_wd_no_reset: assert property (
    @(posedge CLK) disable iff (RST)
    (!rst_act && !trig) |=> !rst_act)
    else $error("Reset asserted without trigger");

  a_pol_outputs: assert property (
    @(posedge CLK) disable iff (RST)
    RESET_OUT == (rst_act && RESET_POLARITY != `SUP_POL_LOW)
      && RESET_OUT_N == !(rst_act && RESET_POLARITY != `SUP_POL_HIGH))
    else $error("Reset outputs disagree with sequencer");

  a_alarm_latched: assert property (
    @(posedge CLK) disable iff (RST)
    (wd_exp_r && !rst_act && !sin.kick_edge) |=> wd_exp_r)
    else $error("Watchdog alarm cleared without kick");

  a_wdo_release: assert property (
    @(posedge CLK) disable iff (RST)
    $fell(sin.supply_low) |=> WATCHDOG_ALARM_OUT_N)
    else $error("Alarm not lifted at supply recovery");

  a_pf_no_reset: assert property (
    @(posedge CLK) disable iff (RST)
    (!rst_act && !trig && $changed(sin.pf_low)) |=> !rst_act)
    else $error("Power-fail change touched reset");

  a_manual_idle: assert property (
    @(posedge CLK) disable iff (RST)
    (!rst_act && sin.manual_n && !sin.supply_low) |=> !rst_act)
    else $error("High manual input caused reset");

endmodule
